// File: rtl/ees_pkg.sv
// Shared constants and types for the two-wire EEPROM port and its master
package ees_pkg;
  localparam int CLK_PERIOD_NS          = 100;
  // Widest spike that must never be taken as an edge
  localparam int GLITCH_REJECT_WIDTH_NS = 50;
  localparam int GLITCH_CYC             =
    (GLITCH_REJECT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least wait after a clock fall before the slave moves its data line
  localparam int TX_HOLD_NS             = 200;
  localparam int TX_HOLD_CYC            =
    (TX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest self-timed program cycle
  localparam int PROG_TIME_MS           = 5;
  localparam int PROG_CYC               =
    PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // Least clock-low time before the slave abandons the transfer
  localparam int BUS_STALL_LIMIT_MS     = 25;
  localparam int BUS_STALL_LIMIT_CYC    =
    (BUS_STALL_LIMIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Serial clock made by the master, four quarters to a bit
  localparam int SERIAL_CLOCK_RATE_KHZ  = 500;
  localparam int QTR_CYC                =
    1000000 / (SERIAL_CLOCK_RATE_KHZ * 4 * CLK_PERIOD_NS);

  localparam int       BYTE_W        = 8;
  localparam int       MEM_DEPTH     = 512;
  localparam int       RX_BUF_DEPTH  = 2;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic [3:0] CODE_ARRAY    = 4'hA;
  localparam logic [3:0] CODE_PROT     = 4'h6;
  localparam logic [2:0] CS_BANK0      = 3'h6;
  localparam logic [2:0] CS_BANK1      = 3'h7;
  localparam logic [2:0] CS_CLEAR_ALL  = 3'h3;
  // Select field per block, block 0 in the low three bits
  localparam logic [11:0] SET_BLOCK_PROTECT_CS =
    {3'h0, 3'h5, 3'h4, 3'h1};
  localparam logic       BANK_RESET    = 1'b0;
  localparam logic [3:0] PROTECT_RESET = 4'h0;

  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_CTRL  = 3'h1,
    D_ADDR  = 3'h3,
    D_WDATA = 3'h2,
    D_READ  = 3'h6,
    D_DUMMY = 3'h7
  } ees_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_WAIT = 2'h1,
    H_BYTE = 2'h3,
    H_COND = 2'h2
  } ees_host_state_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_STOP  = 2'h3
  } ees_op_t;
endpackage

// File: rtl/ees_bus_if.sv
// Open-drain two-wire bus joining the master end and the slave end
interface ees_bus_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Pull-up wins unless some end drives its pin
  assign scl = scl_m_oe ? scl_m_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

  modport dev (
    input  scl,
    input  sda,
    output sda_s_o,
    output sda_s_oe
  );
  modport host (
    input  scl,
    input  sda,
    output scl_m_o,
    output scl_m_oe,
    output sda_m_o,
    output sda_m_oe
  );
endinterface

// File: rtl/ees_buf2.sv
// Small valid/ready buffer for bytes read back by the master
module ees_buf2 #(
  parameter int WIDTH = ees_pkg::BYTE_W,
  parameter int DEPTH = ees_pkg::RX_BUF_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import ees_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  wire [AW-1:0] next_wr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] next_rd = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign in_ready  = fill != (AW + 1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data  = slot[rd_ptr];

  always_ff @(posedge mclk) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) wr_ptr <= next_wr;
      if (pop) rd_ptr <= next_rd;
      if (push && !pop) fill <= fill + 1'b1;
      else if (pop && !push) fill <= fill - 1'b1;
    end
  end
endmodule

// File: rtl/ees_dev.sv
// Two-wire EEPROM slave end: line filtering, framing, addressing, array
// Behaviour
// - Master alone clocks bus and frames transfers
// - Master picks direction; clock paces every bit
// - New transfer starts only on idle bus
// - Both lines high means bus idle
// - Data fall during clock high is start
// - Data change during clock high is framing
// - Slave only pulls low, changes at clock low
// - Array access needs chip pins to match
// - Protect and bank commands skip pin match
// - Protect commands need high voltage detect
// - Program cycle ends within five milliseconds
// - Master keeps clock at ten kilohertz minimum; ees_host holds it low with no limit while its read buffer is full
// - Pulses up to fifty nanoseconds are ignored
// - Output waits 200 ns after clock fall
// - Two banks, four separately protected blocks
// - Data rise during clock high is stop
// - Long clock low resets interface until start
// - Ack each byte; none while programming
// - Upper nibble selects array or protect space
module ees_dev #(
  parameter int PROG_CYCLES  = ees_pkg::PROG_CYC,
  parameter int STALL_CYCLES = ees_pkg::BUS_STALL_LIMIT_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  ees_bus_if.dev          bus,
  input  wire logic [1:0] addr_pin_zero_hv_input,
  input  wire logic       addr_pin_one,
  input  wire logic       addr_pin_two,
  output logic            prog_busy,
  output logic            bank_sel,
  output logic      [3:0] block_protect
);
  import ees_pkg::*;

  logic [1:0]     line_s1;
  logic [1:0]     line_s2;
  logic [1:0]     line_prev;
  wire  [1:0]     line_f;
  logic [3:0]     pin_s1;
  logic [3:0]     pin_s2;
  ees_dev_state_t st;
  ees_dev_state_t pend_st;
  logic [3:0]     bitn;
  logic [7:0]     sh;
  logic [7:0]     tx;
  logic [7:0]     ptr;
  logic           ack_ok;
  logic           wrote;
  logic [23:0]    prog_cnt;
  logic [23:0]    stall_cnt;
  logic [3:0]     dly;
  logic           oe;
  logic [7:0]     mem [0:MEM_DEPTH-1];

  // Bit 0 is the clock line, bit 1 the data line
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_s1 <= 2'h3;
      line_s2 <= 2'h3;
      pin_s1  <= 4'h0;
      pin_s2  <= 4'h0;
    end else begin
      line_s1 <= {bus.sda, bus.scl};
      line_s2 <= line_s1;
      pin_s1  <= {addr_pin_two, addr_pin_one, addr_pin_zero_hv_input};
      pin_s2  <= pin_s1;
    end
  end

  // A new level is taken only after it held longer than a spike can
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic [3:0] cnt;
      logic       filt;
      assign line_f[gi] = filt;
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          cnt  <= 4'h0;
          filt <= 1'b1;
        end else if (line_s2[gi] == filt) begin
          cnt <= 4'h0;
        end else if (cnt == 4'(GLITCH_CYC)) begin
          filt <= line_s2[gi];
          cnt  <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) line_prev <= 2'h3;
    else line_prev <= line_f;
  end

  wire scl_f = line_f[0];
  wire sda_f = line_f[1];
  wire scl_p = line_prev[0];
  wire sda_p = line_prev[1];
  wire start_ev = scl_f & scl_p & sda_p & ~sda_f;
  wire stop_ev  = scl_f & scl_p & ~sda_p & sda_f;
  wire rise_ev  = scl_f & ~scl_p;
  wire fall_ev  = ~scl_f & scl_p;

  wire [2:0] chip_pins = {pin_s2[3], pin_s2[2], pin_s2[0]};
  wire       hv_on     = pin_s2[1];
  wire       busy      = prog_cnt != 24'h0;
  wire       stall_hit = stall_cnt == 24'(STALL_CYCLES - 1);

  wire [7:0] rx_byte = {sh[6:0], sda_f};
  wire [3:0] rx_code = rx_byte[7:4];
  wire [2:0] rx_cs   = rx_byte[3:1];
  wire       rx_rd   = rx_byte[0];
  wire [7:0] ptr_inc = ptr + 8'h01;
  wire [7:0] page_inc = {ptr[7:4], ptr[3:0] + 4'h1};
  wire [1:0] blk     = {bank_sel, ptr[7]};

  wire is_array = (rx_code == CODE_ARRAY) &&
                  (rx_cs == chip_pins);
  wire is_prot  = rx_code == CODE_PROT;
  wire is_sba   = is_prot & ~rx_rd & (rx_cs[2:1] == CS_BANK0[2:1]);
  wire is_rba   = is_prot & rx_rd & (rx_cs == CS_BANK0);
  wire is_cwp   = is_prot & ~rx_rd & (rx_cs == CS_CLEAR_ALL);
  wire [3:0] swp_hit;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_swp
      assign swp_hit[gi] = is_prot & ~rx_rd &
                           (rx_cs == SET_BLOCK_PROTECT_CS[3*gi +: 3]);
    end
  endgenerate
  wire is_swp = |swp_hit;

  // Busy array stays silent on its control byte
  wire ctrl_ack = ~busy & (is_array | is_sba | (is_rba & ~bank_sel) |
                  ((is_swp | is_cwp) & hv_on));
  wire ees_dev_state_t ctrl_next = ees_dev_state_t'(
    busy ? D_IDLE :
    is_array ? (rx_rd ? D_READ : D_ADDR) :
    (is_sba | is_rba | ctrl_ack) ? D_DUMMY : D_IDLE);
  wire wr_ok  = ~block_protect[blk];
  wire rx_end = rise_ev && (bitn == BYTE_LAST_BIT) &&
                (st != D_IDLE) && (st != D_READ);
  wire ctrl_end = rx_end && (st == D_CTRL);
  wire mem_we   = rx_end && (st == D_WDATA) && wr_ok;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= D_IDLE;
      pend_st <= D_IDLE;
      bitn    <= 4'h0;
      sh      <= 8'h00;
      tx      <= 8'hFF;
      ptr     <= 8'h00;
      ack_ok  <= 1'b0;
    end else if (start_ev) begin
      st   <= D_CTRL;
      bitn <= 4'h0;
    end else if (stop_ev || stall_hit) begin
      st <= D_IDLE;
    end else if (rise_ev && st != D_IDLE) begin
      if (bitn == ACK_SLOT) begin
        bitn <= 4'h0;
        if (st == D_READ) begin
          // Master's acknowledge decides whether to go on sending
          if (sda_f) st <= D_IDLE;
          ptr <= ptr_inc;
          tx  <= mem[{bank_sel, ptr_inc}];
        end else begin
          st <= pend_st;
        end
      end else begin
        bitn <= bitn + 4'h1;
        sh   <= rx_byte;
        if (rx_end) begin
          case (st)
            D_CTRL: begin
              ack_ok  <= ctrl_ack;
              pend_st <= ctrl_next;
              tx      <= mem[{bank_sel, ptr}];
            end
            D_ADDR: begin
              ack_ok  <= 1'b1;
              ptr     <= rx_byte;
              pend_st <= D_WDATA;
            end
            D_WDATA: begin
              ack_ok  <= wr_ok;
              pend_st <= ees_dev_state_t'(wr_ok ? D_WDATA : D_DUMMY);
              if (wr_ok) ptr <= page_inc;
            end
            default: begin
              ack_ok  <= 1'b0;
              pend_st <= D_DUMMY;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[{bank_sel, ptr}] <= rx_byte;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank_sel      <= BANK_RESET;
      block_protect <= PROTECT_RESET;
    end else if (ctrl_end && ctrl_ack) begin
      if (is_sba) bank_sel <= rx_cs[0];
      if (is_cwp) block_protect <= PROTECT_RESET;
      else if (is_swp) block_protect <= block_protect | swp_hit;
    end
  end

  // Timer starts only on the stop that closes a write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrote    <= 1'b0;
      prog_cnt <= 24'h0;
    end else begin
      if (mem_we) wrote <= 1'b1;
      else if (stop_ev) wrote <= 1'b0;
      if (stop_ev && wrote) prog_cnt <= 24'(PROG_CYCLES);
      else if (busy) prog_cnt <= prog_cnt - 24'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) stall_cnt <= 24'h0;
    else if (scl_f || st == D_IDLE) stall_cnt <= 24'h0;
    else stall_cnt <= stall_cnt + 24'h1;
  end

  wire tx_low  = (st == D_READ) && (bitn < ACK_SLOT) && !tx[~bitn[2:0]];
  wire ack_low = (st != D_READ) && (st != D_IDLE) &&
                 (bitn == ACK_SLOT) && ack_ok;

  // Data is driven only a fixed delay after a clock fall; start, stop, stall or idle release it at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dly <= 4'h0;
      oe  <= 1'b0;
    end else begin
      if (fall_ev) dly <= 4'(TX_HOLD_CYC);
      else if (dly != 4'h0) dly <= dly - 4'h1;
      if (start_ev || stop_ev || stall_hit || st == D_IDLE) oe <= 1'b0;
      else if (dly == 4'h1) oe <= tx_low | ack_low;
    end
  end

  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = oe;
  assign prog_busy    = busy;
endmodule

// File: rtl/ees_host.sv
// Two-wire bus master end: makes the clock and frames each operation
module ees_host (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  ees_bus_if.host              bus,
  input  wire logic            cmd_valid,
  output logic                 cmd_ready,
  input  wire ees_pkg::ees_op_t cmd_op,
  input  wire logic      [7:0] cmd_data,
  input  wire logic            cmd_ack,
  output logic                 done,
  output logic                 slave_acked,
  output logic                 rx_valid,
  input  wire logic            rx_ready,
  output logic           [7:0] rx_data
);
  import ees_pkg::*;

  ees_host_state_t st;
  ees_op_t         op;
  logic [3:0]      qcnt;
  logic [1:0]      quarter;
  logic [3:0]      bitn;
  logic [7:0]      sh;
  logic            mack;
  logic            sda_s1;
  logic            sda_in;
  logic            scl_oe;
  logic            sda_oe;
  logic            buf_ready;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1 <= 1'b1;
      sda_in <= 1'b1;
    end else begin
      sda_s1 <= bus.sda;
      sda_in <= sda_s1;
    end
  end

  wire q_end  = qcnt == 4'(QTR_CYC - 1);
  wire in_bit = bitn < ACK_SLOT;
  wire is_rd  = op == OP_READ;
  // Start: data falls in quarter 2 with clock high; stop: data rises
  wire cond_scl = (op == OP_STOP) ? (quarter != 2'h0) :
                                    (quarter[0] ^ quarter[1]);
  wire cond_sda = (op == OP_STOP) ? quarter[1] : ~quarter[1];
  wire bit_scl  = quarter[0] ^ quarter[1];
  wire bit_sda  = is_rd ? (in_bit ? 1'b1 : ~mack) : (in_bit ? sh[7] : 1'b1);
  wire want_scl = (st == H_COND) ? cond_scl : bit_scl;
  wire want_sda = (st == H_COND) ? cond_sda : bit_sda;
  wire active   = (st == H_COND) || (st == H_BYTE);
  wire last_q   = active && q_end && (quarter == 2'h3);
  wire push     = last_q && (st == H_BYTE) && is_rd && !in_bit;

  assign cmd_ready = st == H_IDLE;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= H_IDLE;
      op          <= OP_STOP;
      qcnt        <= 4'h0;
      quarter     <= 2'h0;
      bitn        <= 4'h0;
      sh          <= 8'h00;
      mack        <= 1'b0;
      done        <= 1'b0;
      slave_acked <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st)
        H_IDLE: begin
          if (cmd_valid) begin
            op      <= cmd_op;
            sh      <= cmd_data;
            mack    <= cmd_ack;
            qcnt    <= 4'h0;
            quarter <= 2'h0;
            bitn    <= 4'h0;
            if (cmd_op == OP_START || cmd_op == OP_STOP) st <= H_COND;
            else if (cmd_op == OP_READ && !buf_ready) st <= H_WAIT;
            else st <= H_BYTE;
          end
        end
        H_WAIT: begin
          // Clock stays low until the reader frees a slot
          if (buf_ready) st <= H_BYTE;
        end
        H_COND, H_BYTE: begin
          qcnt <= q_end ? 4'h0 : qcnt + 4'h1;
          if (q_end) quarter <= quarter + 2'h1;
          if (q_end && quarter == 2'h2 && st == H_BYTE) begin
            if (in_bit) sh <= {sh[6:0], sda_in};
            else if (!is_rd) slave_acked <= ~sda_in;
          end
          if (last_q) begin
            if (st == H_COND || !in_bit) begin
              st   <= H_IDLE;
              done <= 1'b1;
            end else begin
              bitn <= bitn + 4'h1;
            end
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  // Lines are held as left between operations; idle after a stop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (active) begin
      scl_oe <= ~want_scl;
      sda_oe <= ~want_sda;
    end
  end

  assign bus.scl_m_o  = 1'b0;
  assign bus.scl_m_oe = scl_oe;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = sda_oe;

  ees_buf2 u_rx_buf (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (sh),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );
endmodule

// File: test/ees_bus_assertions.sv
// Concurrent checks on the two-wire bus between master and slave ends
module ees_bus_assertions #(
  parameter int STALL_CYCLES = 2000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] low_cnt;

  // Clock-low run length; margin below covers the slave's input filter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= scl ? 16'h0000 : low_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  slave_odr_a:
    assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drives the data line high");
  host_odr_a:
    assert property ((scl_m_oe |-> !scl_m_o) and (sda_m_oe |-> !sda_m_o))
    else $error("master drives a line high");
  slave_edge_a:
    assert property (($rose(sda_s_oe) || $fell(sda_s_oe)) |-> !scl)
    else $error("slave data moved while clock high");
  tx_delay_a:
    assert property ($fell(scl) |=> $stable(sda_s_oe) [*2])
    else $error("slave data moved too soon after clock fall");
  high_stable_a:
    assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave data unstable in clock high");
  stall_release_a:
    assert property (low_cnt == STALL_CYCLES + 16 |-> !sda_s_oe)
    else $error("slave still drives after clock stall");
  stop_quiet_a:
    assert property ($rose(sda) && scl |=> (!sda_s_oe) [*8])
    else $error("slave drives data after stop");
  start_quiet_a:
    assert property ($fell(sda) && scl |=> (!sda_s_oe) [*8])
    else $error("slave drives data right after start");
  host_start_a:
    assert property ($rose(sda_m_oe) && scl |-> !sda_s_oe)
    else $error("master starts while slave holds data");

  cover property ($fell(sda) && scl);
  cover property (scl && sda_s_oe);
  cover property (low_cnt == 16'(STALL_CYCLES));
endmodule

// File: test/tb_eeprom_two_wire_slave_port.sv
// Self-checking bench for the two-wire EEPROM port and its master
module tb_eeprom_two_wire_slave_port;
  timeunit 1ns;
  timeprecision 100ps;
  import ees_pkg::*;

  // Short counts keep the run brief; expectations derive from these
  localparam int PROG = 600;
  localparam int STALL = 2000;
  localparam logic [7:0] CTRL = {CODE_ARRAY, 3'h5, 1'b0};
  localparam logic [7:0] PAT [4] = '{8'h5C, 8'hA3, 8'hC6, 8'h3B};

  logic       mclk;
  logic       rst_n;
  logic [1:0] addr_pin_zero_hv_input;
  logic       addr_pin_one;
  logic       addr_pin_two;
  logic       prog_busy;
  logic       bank_sel;
  logic [3:0] block_protect;
  logic       cmd_valid;
  logic       cmd_ready;
  ees_op_t    cmd_op;
  logic [7:0] cmd_data;
  logic       cmd_ack;
  logic       done;
  logic       slave_acked;
  logic       rx_valid;
  logic       rx_ready;
  logic [7:0] rx_data;
  int         err_count;
  int         samples_checked;
  int         cycles;
  time        t0;

  ees_bus_if ees_bus_if_i ();
  ees_dev #(.PROG_CYCLES(PROG), .STALL_CYCLES(STALL)) ees_dev_i (
    .mclk(mclk), .rst_n(rst_n), .bus(ees_bus_if_i.dev),
    .addr_pin_zero_hv_input(addr_pin_zero_hv_input),
    .addr_pin_one(addr_pin_one), .addr_pin_two(addr_pin_two),
    .prog_busy(prog_busy), .bank_sel(bank_sel),
    .block_protect(block_protect));
  ees_host ees_host_i (
    .mclk(mclk), .rst_n(rst_n), .bus(ees_bus_if_i.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .done(done),
    .slave_acked(slave_acked), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data));
  ees_bus_assertions #(.STALL_CYCLES(STALL)) ees_bus_assertions_i (
    .mclk(mclk), .rst_n(rst_n),
    .scl_m_o(ees_bus_if_i.scl_m_o), .scl_m_oe(ees_bus_if_i.scl_m_oe),
    .sda_m_o(ees_bus_if_i.sda_m_o), .sda_m_oe(ees_bus_if_i.sda_m_oe),
    .sda_s_o(ees_bus_if_i.sda_s_o), .sda_s_oe(ees_bus_if_i.sda_s_oe),
    .scl(ees_bus_if_i.scl), .sda(ees_bus_if_i.sda));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Called at a falling edge while the master is idle
  task automatic op(input ees_op_t o, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    cmd_op = o;
    cmd_data = d;
    cmd_ack = a;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 6000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 6000) begin
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] d, input logic a);
    op(OP_WRITE, d, 1'b0);
    check(8'(slave_acked), 8'(a));
  endtask

  task automatic st();
    op(OP_START, 8'h00, 1'b0);
  endtask

  task automatic sp();
    op(OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic a);
    op(OP_READ, 8'h00, a);
  endtask

  task automatic wt();
    int n;
    n = 0;
    while (prog_busy !== 1'b0 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic pop(input logic [7:0] e);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    check(rx_data, e);
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    addr_pin_zero_hv_input = 2'b01;
    addr_pin_one = 1'b0;
    addr_pin_two = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    rx_ready = 1'b0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    check(8'(prog_busy), 8'h00);
    check(8'(bank_sel), 8'(BANK_RESET));
    check(8'(block_protect), 8'(PROTECT_RESET));
    // Page write, then a control byte while the program cycle runs
    st();
    wr(CTRL, 1'b1);
    wr(8'h10, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(PAT[i], 1'b1);
    end
    sp();
    t0 = $time;
    st();
    check(8'(prog_busy), 8'h01);
    wr(CTRL, 1'b0);
    sp();
    wt();
    check(8'(($time - t0) <= PROG * 100), 8'h01);
    // Read back across a repeated start
    st();
    wr(CTRL, 1'b1);
    wr(8'h10, 1'b1);
    st();
    wr(CTRL | 8'h01, 1'b1);
    rd(1'b1);
    rd(1'b0);
    sp();
    pop(PAT[0]);
    pop(PAT[1]);
    for (int i = 0; i < 3; i++) begin
      st();
      wr(CTRL ^ (8'h02 << i), 1'b0);
      sp();
    end
    // Bank commands ignore the chip pins; dummy byte is not acked
    for (int b = 1; b >= 0; b--) begin
      wt();
      st();
      wr({CODE_PROT, b ? CS_BANK1 : CS_BANK0, 1'b0}, 1'b1);
      wr(8'h00, 1'b0);
      sp();
      check(8'(bank_sel), 8'(b));
    end
    // Bank query acks while bank 0 is selected; dummy byte reads idle
    wt();
    st();
    wr({CODE_PROT, CS_BANK0, 1'b1}, 1'b1);
    rd(1'b0);
    sp();
    pop(8'hFF);
    wt();
    st();
    wr({CODE_PROT, SET_BLOCK_PROTECT_CS[2:0], 1'b0}, 1'b0);
    sp();
    check(8'(block_protect), 8'h00);
    addr_pin_zero_hv_input = 2'b11;
    for (int i = 0; i < 4; i++) begin
      wt();
      st();
      wr({CODE_PROT, SET_BLOCK_PROTECT_CS[3*i +: 3], 1'b0}, 1'b1);
      sp();
      check(8'(block_protect), 8'((2 << i) - 1));
    end
    wt();
    st();
    wr(CTRL, 1'b1);
    wr(8'h20, 1'b1);
    wr(8'h99, 1'b0);
    sp();
    wt();
    st();
    wr({CODE_PROT, CS_CLEAR_ALL, 1'b0}, 1'b1);
    sp();
    check(8'(block_protect), 8'h00);
    addr_pin_zero_hv_input = 2'b01;
    // Fill the read buffer so the master stalls the clock too long
    wt();
    st();
    wr(CTRL, 1'b1);
    wr(8'h11, 1'b1);
    st();
    wr(CTRL | 8'h01, 1'b1);
    rd(1'b1);
    rd(1'b1);
    fork
      rd(1'b0);
      begin
        repeat (STALL + 300) @(negedge mclk);
        check(8'(cmd_ready), 8'h00);
        pop(PAT[1]);
        pop(PAT[2]);
      end
    join
    pop(8'hFF);
    check(8'(rx_valid), 8'h00);
    sp();
    finish_test();
  end
endmodule
